// file: common/pss_pkg.sv
/*
 * Constants, register map and types for the slave clock servo.
 * Assumes a single 50 MHz clock and a plain strobe register port.
 */
// Summary of operation
// - Outlier threshold selectable: 50,60,80,100,120,150,200,500,1000,2000 us.
// - Count rejected outlier syncs from reset, readable, never cleared by software.
// - Discipline local clock only in slave mode, one offset per sync.
// - Offset times offset gain applied as offset correction for past error.
// - Offset times separate rate gain applied as rate correction for future error.
// - Gain of exactly 1.0 passes the full measured offset at once, clamped to the step limit when locked.
// - When locked, offset correction per sync clamped to a step limit in ns.
// - Sync with offset above threshold is ignored, no correction applied.
// - Report state: synchronizing, locked, or not applicable.
package pss_pkg;

    // Data, address and interrupt status widths
    localparam int DW   = 32;
    localparam int AW   = 8;
    localparam int IRQW = 3;

    // Register byte offsets
    localparam logic [AW-1:0] ADDR_THRESH = 8'h00;
    localparam logic [AW-1:0] ADDR_OGAIN  = 8'h04;
    localparam logic [AW-1:0] ADDR_RGAIN  = 8'h08;
    localparam logic [AW-1:0] ADDR_LIMIT  = 8'h0c;
    localparam logic [AW-1:0] ADDR_REJECT = 8'h10;
    localparam logic [AW-1:0] ADDR_STATE  = 8'h14;
    localparam logic [AW-1:0] ADDR_ISTAT  = 8'h18;
    localparam logic [AW-1:0] ADDR_IMASK  = 8'h1c;
    localparam logic [AW-1:0] ADDR_CTRL   = 8'h20;

    // Gains are unsigned Q16.16
    localparam int            GAIN_FRAC = 16;
    localparam logic [DW-1:0] GAIN_ONE  = 32'h0001_0000;

    // Reset values
    localparam logic [3:0]    THRESH_RST = 4'h3;
    localparam logic [DW-1:0] OGAIN_RST  = 32'h0000_8000;
    localparam logic [DW-1:0] RGAIN_RST  = 32'h0000_1000;
    localparam logic [DW-1:0] LIMIT_RST  = 32'h000f_4240;

    // Interrupt status bit positions
    localparam int IRQ_OUTLIER = 0;
    localparam int IRQ_CORR    = 1;
    localparam int IRQ_LOCK    = 2;

    // Control register bit
    localparam int CTRL_SLAVE = 0;

    // Outlier threshold table in microseconds
    localparam int unsigned NS_PER_US     = 1000;
    localparam logic [3:0]  THR_SEL_MAX   = 4'h9;
    localparam int unsigned THR_US [0:9]  = '{50, 60, 80, 100, 120, 150, 200, 500, 1000, 2000};
    localparam logic [DW-1:0] THR_NS_MIN  = 32'(THR_US[0] * NS_PER_US);
    localparam logic [DW-1:0] THR_NS_MAX  = 32'(THR_US[9] * NS_PER_US);

    // Syncs accepted before declaring lock
    localparam int LOCK_COUNT_DEF = 4;

    typedef enum logic [1:0] {
        PSS_NA      = 2'b00,
        PSS_SYNCING = 2'b01,
        PSS_LOCKED  = 2'b10
    } pss_state_t;

    // Threshold in ns; codes above the table pick the widest
    function automatic logic [DW-1:0] pss_thr_ns(input logic [3:0] sel);
        logic [3:0] idx;
        idx = (sel > THR_SEL_MAX) ? THR_SEL_MAX : sel;
        return 32'(THR_US[idx] * NS_PER_US);
    endfunction

endpackage

// file: common/pss_mul_if.sv
/*
 * Carrier between the servo core and its gain multipliers.
 * Assumes the multiplier answers combinationally.
 */
`timescale 1ns/10ps
interface pss_mul_if #(parameter int W = 32);
    logic signed [W-1:0] operand;
    logic        [W-1:0] gain;
    logic signed [W-1:0] product;

    modport src (output operand, output gain, input product);
    modport mul (input operand, input gain, output product);
endinterface

// file: rtl/pss_gain_mul.sv
/*
 * Signed offset times unsigned Q16.16 gain, combinational.
 * Assumes the caller registers the product.
 */
`timescale 1ns/10ps
module pss_gain_mul (
    pss_mul_if.mul m
);
    localparam int W = $bits(m.operand);
    localparam int F = pss_pkg::GAIN_FRAC;

    logic signed [2*W:0] full;

    // Full product, then drop the fraction; 1.0 returns the operand unchanged
    // unity gain exact
    always_comb begin
        full      = m.operand * $signed({1'b0, m.gain});
        m.product = full[F+W-1:F];
    end
endmodule

// file: rtl/pss_servo.sv
/*
 * Slave clock servo: outlier filter, gain scaling, step limit,
 * lock state, register port and interrupt.
 * Assumes sync offsets arrive synchronous to MCLK, one-cycle strobe,
 * offset in signed ns (local minus master).
 */
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module pss_servo #(
    parameter int LOCK_COUNT = pss_pkg::LOCK_COUNT_DEF
) (
    input  wire logic                    MCLK,
    input  wire logic                    RSTN,
    input  wire logic [pss_pkg::AW-1:0]  ADDR,
    input  wire logic [pss_pkg::DW-1:0]  WDATA,
    input  wire logic                    WR,
    input  wire logic                    RD,
    output logic      [pss_pkg::DW-1:0]  RDATA,
    output logic                         IRQ,
    input  wire logic                    SYNC_VALID,
    input  wire logic signed [pss_pkg::DW-1:0] SYNC_OFFSET,
    output logic                         CORR_VALID,
    output logic signed [pss_pkg::DW-1:0] CORR_OFFSET,
    output logic signed [pss_pkg::DW-1:0] CORR_RATE,
    output logic [1:0]                   SERVO_STATE
);
    localparam int DW  = pss_pkg::DW;
    localparam int LCW = (LOCK_COUNT > 1) ? $clog2(LOCK_COUNT) : 1;
    localparam logic [LCW-1:0] LOCK_LAST = LCW'(LOCK_COUNT - 1);
    localparam logic [DW-1:0]  CNT_ONE   = 32'h0000_0001;

    // Complete block state
    typedef struct packed {
        logic [3:0]                thr_sel;
        logic [DW-1:0]             ogain;
        logic [DW-1:0]             rgain;
        logic [DW-1:0]             limit;
        logic                      slave_en;
        logic [DW-1:0]             reject_cnt;
        logic [pss_pkg::IRQW-1:0]  istat;
        logic [pss_pkg::IRQW-1:0]  imask;
        pss_pkg::pss_state_t       state;
        logic [LCW-1:0]            lock_cnt;
        logic                      pend;
        logic signed [DW-1:0]      sample;
        logic [DW-1:0]             rdata;
        logic                      irq;
        logic                      corr_valid;
        logic signed [DW-1:0]      corr_off;
        logic signed [DW-1:0]      corr_rate;
    } pss_st_t;

    pss_st_t q;
    pss_st_t d;

    pss_mul_if #(.W(DW)) off_if ();
    pss_mul_if #(.W(DW)) rate_if ();

    logic [DW-1:0]        thr_ns;
    logic [DW-1:0]        abs_off;
    logic                 outlier;
    logic signed [DW:0]   lim_pos;
    logic signed [DW:0]   lim_neg;
    logic signed [DW:0]   off_ext;
    logic signed [DW-1:0] off_prod;
    logic signed [DW-1:0] rate_prod;
    logic signed [DW-1:0] off_clamped;
    logic                 rd_clear;
    logic [pss_pkg::IRQW-1:0] ev;

    // Gain multipliers share the held sample
    assign off_if.operand  = q.sample;
    assign off_if.gain     = q.ogain;
    assign rate_if.operand = q.sample;
    assign rate_if.gain    = q.rgain;
    assign off_prod        = off_if.product;
    assign rate_prod       = rate_if.product;

    pss_gain_mul u_off_mul (
        .m (off_if.mul)
    );

    pss_gain_mul u_rate_mul (
        .m (rate_if.mul)
    );

    assign thr_ns  = pss_pkg::pss_thr_ns(q.thr_sel);
    assign abs_off = SYNC_OFFSET[DW-1] ? DW'(-SYNC_OFFSET) : SYNC_OFFSET;
    assign outlier = abs_off > thr_ns;

    always_comb begin
        lim_pos     = $signed({1'b0, q.limit});
        lim_neg     = -lim_pos;
        off_ext     = {off_prod[DW-1], off_prod};
        off_clamped = off_prod;
        if (off_ext > lim_pos) begin
            off_clamped = lim_pos[DW-1:0];
        end else if (off_ext < lim_neg) begin
            off_clamped = lim_neg[DW-1:0];
        end
    end

    // Next state of everything
    always_comb begin
        d            = q;
        d.pend       = 1'b0;
        d.corr_valid = 1'b0;
        d.rdata      = '0;
        ev           = '0;
        rd_clear     = RD && (ADDR == pss_pkg::ADDR_ISTAT);

        if (!q.slave_en) begin
            d.state    = pss_pkg::PSS_NA;
            d.lock_cnt = '0;
        end else begin
            if (q.state == pss_pkg::PSS_NA) begin
                d.state = pss_pkg::PSS_SYNCING;
            end
            if (SYNC_VALID) begin
                if (outlier) begin
                    d.reject_cnt = q.reject_cnt + CNT_ONE;
                    ev[pss_pkg::IRQ_OUTLIER] = 1'b1;
                end else begin
                    d.sample = SYNC_OFFSET;
                    d.pend   = 1'b1;
                    if (q.state == pss_pkg::PSS_SYNCING) begin
                        if (q.lock_cnt == LOCK_LAST) begin
                            d.state = pss_pkg::PSS_LOCKED;
                            ev[pss_pkg::IRQ_LOCK] = 1'b1;
                        end else begin
                            d.lock_cnt = q.lock_cnt + LCW'(1);
                        end
                    end
                end
            end
            if (q.pend) begin
                d.corr_valid = 1'b1;
                d.corr_off   = (q.state == pss_pkg::PSS_LOCKED) ? off_clamped : off_prod;
                d.corr_rate  = rate_prod;
                ev[pss_pkg::IRQ_CORR] = 1'b1;
            end
        end

        // Register writes
        if (WR) begin
            case (ADDR)
                pss_pkg::ADDR_THRESH: d.thr_sel  = WDATA[3:0];
                pss_pkg::ADDR_OGAIN:  d.ogain    = WDATA;
                pss_pkg::ADDR_RGAIN:  d.rgain    = WDATA;
                pss_pkg::ADDR_LIMIT:  d.limit    = WDATA;
                pss_pkg::ADDR_IMASK:  d.imask    = WDATA[pss_pkg::IRQW-1:0];
                pss_pkg::ADDR_CTRL:   d.slave_en = WDATA[pss_pkg::CTRL_SLAVE];
                default:              d.thr_sel  = q.thr_sel;
            endcase
        end

        // Register reads, data valid next cycle
        if (RD) begin
            case (ADDR)
                pss_pkg::ADDR_THRESH: d.rdata = DW'(q.thr_sel);
                pss_pkg::ADDR_OGAIN:  d.rdata = q.ogain;
                pss_pkg::ADDR_RGAIN:  d.rdata = q.rgain;
                pss_pkg::ADDR_LIMIT:  d.rdata = q.limit;
                pss_pkg::ADDR_REJECT: d.rdata = q.reject_cnt;
                pss_pkg::ADDR_STATE:  d.rdata = DW'(q.state);
                pss_pkg::ADDR_ISTAT:  d.rdata = DW'(q.istat);
                pss_pkg::ADDR_IMASK:  d.rdata = DW'(q.imask);
                pss_pkg::ADDR_CTRL:   d.rdata = DW'(q.slave_en);
                default:              d.rdata = '0;
            endcase
        end

        // Sticky status, read clears, a new event wins
        d.istat = (rd_clear ? '0 : q.istat) | ev;
        d.irq   = |(d.istat & d.imask);
    end

    // State register
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            q         <= '0;
            q.thr_sel <= pss_pkg::THRESH_RST;
            q.ogain   <= pss_pkg::OGAIN_RST;
            q.rgain   <= pss_pkg::RGAIN_RST;
            q.limit   <= pss_pkg::LIMIT_RST;
            q.state   <= pss_pkg::PSS_NA;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign RDATA       = q.rdata;
    assign IRQ         = q.irq;
    assign CORR_VALID  = q.corr_valid;
    assign CORR_OFFSET = q.corr_off;
    assign CORR_RATE   = q.corr_rate;
    assign SERVO_STATE = q.state;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    a_thresh_range: assert property (thr_ns >= pss_pkg::THR_NS_MIN && thr_ns <= pss_pkg::THR_NS_MAX)
        else $error("threshold outside table");

    // counter only steps up by one
    a_reject_step: assert property (!$stable(q.reject_cnt) |-> q.reject_cnt == $past(q.reject_cnt) + CNT_ONE)
        else $error("reject counter moved wrongly");

    a_slave_only: assert property (CORR_VALID |-> $past(q.slave_en) && $past(q.pend))
        else $error("correction outside slave mode");

    a_offset_gain: assert property (q.pend && q.slave_en && q.state != pss_pkg::PSS_LOCKED
        |=> CORR_VALID && CORR_OFFSET == $past(off_prod))
        else $error("offset correction mismatch");

    a_rate_gain: assert property (q.pend && q.slave_en |=> CORR_VALID && CORR_RATE == $past(rate_prod))
        else $error("rate correction mismatch");

    a_unity_pass: assert property (q.pend && q.slave_en && q.rgain == pss_pkg::GAIN_ONE
        |=> CORR_RATE == $past(q.sample))
        else $error("unity gain not exact");

    a_unity_offset: assert property (q.pend && q.slave_en && q.state != pss_pkg::PSS_LOCKED
        && q.ogain == pss_pkg::GAIN_ONE |=> CORR_OFFSET == $past(q.sample))
        else $error("unity offset gain not exact");

    a_step_limit: assert property (q.pend && q.slave_en && q.state == pss_pkg::PSS_LOCKED
        |=> $signed({CORR_OFFSET[DW-1], CORR_OFFSET}) <= $signed({1'b0, $past(q.limit)})
            && $signed({CORR_OFFSET[DW-1], CORR_OFFSET}) >= -$signed({1'b0, $past(q.limit)}))
        else $error("locked step over limit");

    a_outlier_drop: assert property (SYNC_VALID && q.slave_en && outlier |=> !q.pend ##1 !CORR_VALID)
        else $error("outlier produced correction");

    a_state_na: assert property (!q.slave_en |=> SERVO_STATE == pss_pkg::PSS_NA
        ##1 (q.slave_en || SERVO_STATE == pss_pkg::PSS_NA))
        else $error("state not applicable expected");

endmodule

// file: bench/pss_sync_src.sv
/*
 * Far-side model of the time master: hands the servo one sync offset per call.
 * Assumes it is clocked by the servo's MCLK and called from the bench.
 */
`timescale 1ns/10ps
module pss_sync_src (
    input  wire logic                           MCLK,
    output logic                                SYNC_VALID,
    output logic signed [pss_pkg::DW-1:0]       SYNC_OFFSET
);
    // Idle at time zero
    initial begin
        SYNC_VALID  = 1'b0;
        SYNC_OFFSET = 32'h0;
    end

    // One-cycle sync strobe; offset inverted once withdrawn, so no stale match
    task automatic send(input logic signed [pss_pkg::DW-1:0] off);
        @(posedge MCLK);
        SYNC_VALID  <= 1'b1;
        SYNC_OFFSET <= off;
        @(posedge MCLK);
        SYNC_VALID  <= 1'b0;
        SYNC_OFFSET <= ~off;
    endtask
endmodule

// file: bench/tb.sv
/*
 * Self-checking bench for the slave clock servo: register tasks and sync sequences.
 * Assumes the servo and the sync source model are compiled beside it.
 */
`timescale 1ns/10ps
module tb;
    localparam int LOCKN = 2;
    logic                   MCLK, RSTN, WR, RD, IRQ, SYNC_VALID, CORR_VALID;
    logic [7:0]             ADDR;
    logic [31:0]            WDATA, RDATA;
    logic signed [31:0]     SYNC_OFFSET, CORR_OFFSET, CORR_RATE, off, lim;
    logic [1:0]             SERVO_STATE;
    int                     miscompares, check_count, nacc, nrej;

    pss_servo #(.LOCK_COUNT(LOCKN)) i_pss_servo (
        .MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .IRQ(IRQ), .SYNC_VALID(SYNC_VALID), .SYNC_OFFSET(SYNC_OFFSET),
        .CORR_VALID(CORR_VALID), .CORR_OFFSET(CORR_OFFSET), .CORR_RATE(CORR_RATE),
        .SERVO_STATE(SERVO_STATE));
    pss_sync_src i_pss_sync_src (.MCLK(MCLK), .SYNC_VALID(SYNC_VALID), .SYNC_OFFSET(SYNC_OFFSET));

    // 50 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge MCLK);
        miscompares++;
        test_done();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        WR    <= 1'b1;
        ADDR  <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        @(posedge MCLK);
        RD   <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD   <= 1'b0;
        #1;
        chk(RDATA, want);
    endtask

    // Sync, then look at the correction one edge after it is taken
    task automatic sync(input logic signed [31:0] o, input logic v, input logic signed [31:0] eo, er);
        i_pss_sync_src.send(o);
        @(posedge MCLK);
        #1;
        chk(32'(CORR_VALID), 32'(v));
        if (v) begin
            chk(CORR_OFFSET, eo);
            chk(CORR_RATE, er);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {ADDR, WDATA, WR, RD, RSTN} = '0;
        {miscompares, check_count, nacc, nrej} = '0;
        repeat (4) @(posedge MCLK);
        RSTN <= 1'b1;
        rd(pss_pkg::ADDR_THRESH, 32'(pss_pkg::THRESH_RST));
        rd(pss_pkg::ADDR_OGAIN, pss_pkg::OGAIN_RST);
        rd(pss_pkg::ADDR_RGAIN, pss_pkg::RGAIN_RST);
        rd(pss_pkg::ADDR_LIMIT, pss_pkg::LIMIT_RST);
        rd(pss_pkg::ADDR_REJECT, 32'h0);
        rd(pss_pkg::ADDR_STATE, 32'h0);
        rd(8'h24, 32'h0);
        $display("test reset values done");
        sync(32'sh64, 1'b0, 32'sh0, 32'sh0);
        rd(pss_pkg::ADDR_CTRL, 32'h0);
        wr(pss_pkg::ADDR_CTRL, 32'h1);
        wr(pss_pkg::ADDR_IMASK, 32'h7);
        wr(pss_pkg::ADDR_OGAIN, pss_pkg::GAIN_ONE);
        wr(pss_pkg::ADDR_RGAIN, 32'h8000);
        rd(pss_pkg::ADDR_STATE, 32'h1);
        chk(32'(SERVO_STATE), 32'h1);
        $display("test slave enable done");
        // Every threshold: exact edge accepted, one past it rejected
        for (int i = 0; i < 10; i++) begin
            wr(pss_pkg::ADDR_THRESH, 32'(i));
            off = 32'(pss_pkg::THR_US[i] * pss_pkg::NS_PER_US);
            nacc++;
            lim = (nacc >= LOCKN && off > pss_pkg::LIMIT_RST) ? pss_pkg::LIMIT_RST : off;
            sync(off, 1'b1, lim, off >>> 1);
            sync(-off - 1, 1'b0, 32'sh0, 32'sh0);
            nrej++;
        end
        rd(pss_pkg::ADDR_REJECT, 32'(nrej));
        // Read data stands one cycle only
        @(posedge MCLK);
        #1;
        chk(RDATA, 32'h0);
        rd(pss_pkg::ADDR_STATE, 32'h2);
        chk(32'(SERVO_STATE), 32'h2);
        rd(pss_pkg::ADDR_ISTAT, 32'h7);
        chk(32'(IRQ), 32'h0);
        $display("test thresholds done");
        wr(pss_pkg::ADDR_LIMIT, 32'h64);
        sync(-32'sh1388, 1'b1, -32'sh64, -32'sh9c4);
        wr(pss_pkg::ADDR_RGAIN, pss_pkg::GAIN_ONE);
        sync(32'sh32, 1'b1, 32'sh32, 32'sh32);
        rd(pss_pkg::ADDR_ISTAT, 32'h2);
        $display("test step limit done");
        wr(pss_pkg::ADDR_IMASK, 32'h2);
        sync(-32'sh2d_c6c0, 1'b0, 32'sh0, 32'sh0);
        nrej++;
        chk(32'(IRQ), 32'h0);
        wr(pss_pkg::ADDR_IMASK, 32'h1);
        @(posedge MCLK);
        #1;
        chk(32'(IRQ), 32'h1);
        rd(pss_pkg::ADDR_ISTAT, 32'h1);
        chk(32'(IRQ), 32'h0);
        $display("test interrupt done");
        // Codes above the table act as the widest threshold
        wr(pss_pkg::ADDR_THRESH, 32'hf);
        sync(32'sh1e_8480, 1'b1, 32'sh64, 32'sh1e_8480);
        sync(32'sh1e_8481, 1'b0, 32'sh0, 32'sh0);
        nrej++;
        wr(pss_pkg::ADDR_CTRL, 32'h0);
        wr(pss_pkg::ADDR_REJECT, 32'h0);
        rd(pss_pkg::ADDR_STATE, 32'h0);
        chk(32'(SERVO_STATE), 32'h0);
        rd(pss_pkg::ADDR_REJECT, 32'(nrej));
        $display("test slave disable done");
        test_done();
    end
endmodule
